// ### core/stepper_defines.vh
// constants for the feed motor sequencer, which passes PERIOD_W to its step rate divider as the width
`ifndef STEPPER_DEFINES_VH
`define STEPPER_DEFINES_VH

// system clock rate in hertz
`define CLK_HZ          10000000

// step rates in steps per second
`define FAST_PPS        432
`define SLOW_PPS        216

// feed per step in micrometres, for reference by step counting software
`define FEED_UM_PER_STEP 130

// function select codes
`define FUNC_STANDBY    3'h0
`define FUNC_COPY       3'h1
`define FUNC_FAX_SEND   3'h2
`define FUNC_FAX_RECV   3'h3
`define FUNC_PAPER_FEED 3'h4
`define FUNC_DOC_FEED   3'h5

// resolution select codes
`define RES_STANDARD    2'h0
`define RES_FINE        2'h1
`define RES_PHOTO       2'h2
`define RES_SUPER_FINE  2'h3

// coil outputs, bit order {b_neg, a_neg, b_pos, a_pos}
`define COILS_OFF       4'h0
`define COIL_A          4'h1
`define COIL_AB         4'h3
`define COIL_B          4'h2
`define COIL_BNA        4'h6
`define COIL_NA         4'h4
`define COIL_NANB       4'hc
`define COIL_NB         4'h8
`define COIL_NBA        4'h9

// reset value and register widths
`define RESET_PHASE_IDX 3'h0
`define STEP_COUNT_W    16
`define PERIOD_W        16

`endif

// ### core/step_rate_divider.v
// step rate divider: one tick every period clock cycles
`default_nettype none

module step_rate_divider #(
	parameter W = 16
) (
	input  wire         clk,
	input  wire         rstn,
	input  wire         restart,
	input  wire [W-1:0] period,
	output reg          tick
);

	reg [W-1:0] count;

	// restart holds the count at zero so the first tick lands a full period later
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count <= {W{1'b0}};
			tick  <= 1'b0;
		end else if (restart) begin
			count <= {W{1'b0}};
			tick  <= 1'b0;
		end else if (count == period - {{(W-1){1'b0}}, 1'b1}) begin
			count <= {W{1'b0}};
			tick  <= 1'b1; // see (RL9)
		end else begin
			count <= count + {{(W-1){1'b0}}, 1'b1};
			tick  <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ### core/stepper_feed_mode_sequencer.v
// feed stepping motor sequencer: phase pattern, step rate and coil supply control
//
// Overview of operation
// (RL1) fax send standard: two-two pattern, 432 pps
// (RL2) other fine, photo, feed modes: one-two, 432 pps
// (RL3) super fine: one-two pattern at 216 pps
// (RL4) stand-by: all phases off, no steps
// (RL5) receive pause drops high-voltage enable, holding supply
// (RL6) cam home switch low means home position
// (RL7) high-voltage enable high while motor is driven
// (RL8) each step advances pattern one increment in order
// (RL9) step period from clock through programmable divider
`include "stepper_defines.vh"
`default_nettype none

module stepper_feed_mode_sequencer #(
	parameter integer CLK_HZ      = `CLK_HZ,
	parameter integer FAST_CYCLES = CLK_HZ / `FAST_PPS,
	parameter integer SLOW_CYCLES = CLK_HZ / `SLOW_PPS
) (
	input  wire                     clk,
	input  wire                     rstn,
	input  wire [2:0]               func_sel,
	input  wire [1:0]               res_sel,
	input  wire                     run,
	input  wire                     cam_home_switch_n,
	output reg  [3:0]               coil,
	output reg                      hv_enable,
	output reg                      step_pulse,
	output reg                      half_step,
	output reg                      slow_rate,
	output reg  [`STEP_COUNT_W-1:0] step_count,
	output reg                      cam_home,
	output reg                      cam_home_arrive,
	output reg                      func_invalid
);

	localparam [`PERIOD_W-1:0] FAST_PERIOD = FAST_CYCLES[`PERIOD_W-1:0];
	localparam [`PERIOD_W-1:0] SLOW_PERIOD = SLOW_CYCLES[`PERIOD_W-1:0];

	// drive modes, bit order {standby, two_two, slow}
	localparam [2:0] MODE_FAST    = 3'h0;
	localparam [2:0] MODE_SLOW    = 3'h1;
	localparam [2:0] MODE_TWO_TWO = 3'h2;
	localparam [2:0] MODE_STANDBY = 3'h4;

	// eight-entry half-step table; odd entries energise two phases
	function [3:0] coil_pattern;
		input [2:0] idx;
		begin
			case (idx)
				3'h0:    coil_pattern = `COIL_A;
				3'h1:    coil_pattern = `COIL_AB;
				3'h2:    coil_pattern = `COIL_B;
				3'h3:    coil_pattern = `COIL_BNA;
				3'h4:    coil_pattern = `COIL_NA;
				3'h5:    coil_pattern = `COIL_NANB;
				3'h6:    coil_pattern = `COIL_NB;
				3'h7:    coil_pattern = `COIL_NBA;
				default: coil_pattern = `COILS_OFF;
			endcase
		end
	endfunction

	// mode lookup from function and resolution
	function [2:0] drive_mode;
		input [2:0] func;
		input [1:0] res;
		begin
			case (func)
				`FUNC_COPY: begin
					// standard copy runs like fine, at full rate
					if (res == `RES_SUPER_FINE)
						drive_mode = MODE_SLOW; // see (RL3)
					else
						drive_mode = MODE_FAST; // see (RL2)
				end
				`FUNC_FAX_SEND: begin
					case (res)
						`RES_STANDARD:   drive_mode = MODE_TWO_TWO; // see (RL1)
						`RES_SUPER_FINE: drive_mode = MODE_SLOW; // see (RL3)
						default:         drive_mode = MODE_FAST; // see (RL2)
					endcase
				end
				`FUNC_FAX_RECV: begin
					if (res == `RES_SUPER_FINE)
						drive_mode = MODE_SLOW; // see (RL3)
					else
						drive_mode = MODE_FAST; // see (RL2)
				end
				`FUNC_PAPER_FEED,
				`FUNC_DOC_FEED: begin
					drive_mode = MODE_FAST; // see (RL2)
				end
				default: begin
					// codes above document feed fall back to stand-by
					drive_mode = MODE_STANDBY; // see (RL4)
				end
			endcase
		end
	endfunction

	reg  [2:0]              phase_idx;
	reg                     slow_q;
	reg                     home_sync1;
	reg                     home_sync2;
	reg                     home_prev;
	reg  [2:0]              next_idx;
	reg  [`PERIOD_W-1:0]    period;

	// a pause keeps the mode but drops run, so the coils hold without stepping
	wire [2:0] mode      = drive_mode(func_sel, res_sel);
	wire       standby   = mode[2];
	wire       two_two   = mode[1];
	wire       slow      = mode[0];
	wire       active    = run & ~standby;
	wire       restart   = ~active | (slow != slow_q);
	wire       tick;
	wire       step_now  = tick & active;

	always @* begin
		period = slow ? SLOW_PERIOD : FAST_PERIOD; // see (RL3)
	end

	// two-two moves two table entries per step, realigning onto an odd entry
	always @* begin
		if (two_two)
			next_idx = phase_idx + (phase_idx[0] ? 3'h2 : 3'h1); // see (RL8)
		else
			next_idx = phase_idx + 3'h1; // see (RL8)
	end

	// the divider is held while stopped so every run starts on a full period
	step_rate_divider #(
		.W(`PERIOD_W)
	) u_rate (
		.clk     (clk),
		.rstn    (rstn),
		.restart (restart),
		.period  (period),
		.tick    (tick)
	);

	// rate change restarts the divider so no short step appears at the switch
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			slow_q <= 1'b0;
		else
			slow_q <= slow;
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase_idx  <= `RESET_PHASE_IDX;
			coil       <= `COILS_OFF;
			step_pulse <= 1'b0;
			step_count <= {`STEP_COUNT_W{1'b0}};
		end else if (standby) begin
			// phase index is kept so the pattern resumes where the rotor stopped
			coil       <= `COILS_OFF; // see (RL4)
			step_pulse <= 1'b0;
			step_count <= {`STEP_COUNT_W{1'b0}};
		end else if (step_now) begin
			phase_idx  <= next_idx; // see (RL8)
			coil       <= coil_pattern(next_idx);
			step_pulse <= 1'b1;
			step_count <= step_count + {{(`STEP_COUNT_W-1){1'b0}}, 1'b1};
		end else begin
			// coils stay energised between steps to hold position
			coil       <= coil_pattern(phase_idx);
			step_pulse <= 1'b0;
		end
	end

	// full supply only while stepping; any pause, receive included, falls to holding supply
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hv_enable <= 1'b0;
		end else begin
			hv_enable <= active; // see (RL7) see (RL5) see (RL4)
		end
	end

	// status outputs follow the decoded mode and the function code one cycle late
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			half_step    <= 1'b0;
			slow_rate    <= 1'b0;
			func_invalid <= 1'b0;
		end else begin
			half_step    <= ~standby & ~two_two;
			slow_rate    <= ~standby & slow;
			func_invalid <= (func_sel > `FUNC_DOC_FEED);
		end
	end

	// switch is a pin, so it passes two flip-flops before anything reads it
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			home_sync1 <= 1'b1;
			home_sync2 <= 1'b1;
			home_prev  <= 1'b1;
		end else begin
			home_sync1 <= cam_home_switch_n;
			home_sync2 <= home_sync1;
			home_prev  <= home_sync2;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cam_home        <= 1'b0;
			cam_home_arrive <= 1'b0;
		end else begin
			cam_home        <= ~home_sync2; // see (RL6)
			// high to low on the synchronised switch is the arrival at home
			cam_home_arrive <= home_prev & ~home_sync2; // see (RL6)
		end
	end

endmodule

`default_nettype wire

// ### test/feed_motor_model.sv
// coil driver and motor model
`default_nettype none
module feed_motor_model (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [3:0] coil,
	output var  logic       cam_home_switch_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] last;
	logic [2:0] pos;
	// cam passes home once every 8 coil changes
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			last <= 4'h0;
			pos <= 3'h1;
		end else if (coil != last) begin
			last <= coil;
			pos <= pos + 3'h1;
		end
	end
	// switch pulls low at home
	assign cam_home_switch_n = (pos != 3'h0);
endmodule
`default_nettype wire

// ### test/feed_seq_asserts.sv
// assertions on the feed sequencer ports
`default_nettype none
module feed_seq_checker #(
	parameter integer FAST_CYCLES = 20,
	parameter integer SLOW_CYCLES = 40
) (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic [2:0]  func_sel,
	input wire logic [1:0]  res_sel,
	input wire logic        run,
	input wire logic        cam_home_switch_n,
	input wire logic [3:0]  coil,
	input wire logic        hv_enable,
	input wire logic        step_pulse,
	input wire logic        half_step,
	input wire logic        slow_rate,
	input wire logic [15:0] step_count,
	input wire logic        cam_home,
	input wire logic        cam_home_arrive
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0]  up;
	logic [15:0] gap;
	logic        ok;
	wire         sb = func_sel == 3'h0 || func_sel > 3'h5;
	function automatic logic [3:0] nx(input logic [3:0] c);
		logic [3:0] s [8];
		s = '{4'h1, 4'h3, 4'h2, 4'h6, 4'h4, 4'hc, 4'h8, 4'h9};
		nx = 4'h0;
		for (int i = 0; i < 8; i++) if (s[i] == c) nx = s[(i + 1) % 8];
	endfunction
	// ok marks a step that followed another within one unbroken run
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			up <= 3'h0;
			gap <= 16'h0;
			ok <= 1'b0;
		end else begin
			if (up != 3'h4) up <= up + 3'h1;
			gap <= step_pulse ? 16'h1 : gap + 16'h1;
			if (!run || sb || res_sel != $past(res_sel) ||
				func_sel != $past(func_sel)) ok <= 1'b0;
			else if (step_pulse) ok <= 1'b1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_standby;
		sb |=> coil == 4'h0 && !hv_enable && !step_pulse && step_count == 16'h0;
	endproperty
	a_standby: assert property (p_standby) else $error("standby outputs live");
	property p_drive;
		run && !sb |=> hv_enable;
	endproperty
	a_drive: assert property (p_drive) else $error("supply off while driven");
	property p_pause;
		up == 3'h4 && !run && !sb && !$past(sb) |=> !hv_enable && coil == $past(coil);
	endproperty
	a_pause: assert property (p_pause) else $error("pause not holding");
	property p_cam;
		up == 3'h4 |-> cam_home == !$past(cam_home_switch_n, 3);
	endproperty
	a_cam: assert property (p_cam) else $error("cam level wrong");
	property p_arrive;
		up == 3'h4 |-> cam_home_arrive ==
			($past(cam_home_switch_n, 4) && !$past(cam_home_switch_n, 3));
	endproperty
	a_arrive: assert property (p_arrive) else $error("cam arrival wrong");
	property p_two;
		func_sel == 3'h2 && res_sel == 2'h0 |=> !half_step && !slow_rate;
	endproperty
	a_two: assert property (p_two) else $error("two-two mode wrong");
	property p_one;
		!sb && !(func_sel == 3'h2 && res_sel == 2'h0) |=> half_step &&
			slow_rate == ($past(res_sel) == 2'h3 && $past(func_sel) < 3'h4);
	endproperty
	a_one: assert property (p_one) else $error("one-two mode wrong");
	property p_order;
		step_pulse |-> coil == nx($past(coil)) ||
			(!half_step && !$past(^coil) && coil == nx(nx($past(coil))));
	endproperty
	a_order: assert property (p_order) else $error("phase order wrong");
	property p_rate;
		step_pulse && ok |-> gap == (slow_rate ? SLOW_CYCLES : FAST_CYCLES);
	endproperty
	a_rate: assert property (p_rate) else $error("step period wrong");
	c_two: cover property (step_pulse && !half_step);
	c_slow: cover property (step_pulse && slow_rate);
	c_home: cover property (cam_home_arrive);
endmodule
bind stepper_feed_mode_sequencer feed_seq_checker #(
	.FAST_CYCLES(FAST_CYCLES),
	.SLOW_CYCLES(SLOW_CYCLES)
) i_chk (
	.clk               (clk),
	.rstn              (rstn),
	.func_sel          (func_sel),
	.res_sel           (res_sel),
	.run               (run),
	.cam_home_switch_n (cam_home_switch_n),
	.coil              (coil),
	.hv_enable         (hv_enable),
	.step_pulse        (step_pulse),
	.half_step         (half_step),
	.slow_rate         (slow_rate),
	.step_count        (step_count),
	.cam_home          (cam_home),
	.cam_home_arrive   (cam_home_arrive)
);
`default_nettype wire

// ### test/stepper_feed_mode_sequencer_tb.sv
// self-checking bench for the feed sequencer
`default_nettype none
module stepper_feed_mode_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FAST = 20;
	localparam int SLOW = 40;
	logic        clk;
	logic        rstn;
	logic [2:0]  func_sel;
	logic [1:0]  res_sel;
	logic        run;
	logic        cam_home_switch_n;
	logic [3:0]  coil;
	logic        hv_enable;
	logic        step_pulse;
	logic        half_step;
	logic        slow_rate;
	logic [15:0] step_count;
	logic        cam_home;
	logic        cam_home_arrive;
	logic        func_invalid;
	logic [31:0] rng;
	int          fails;
	int          checks;
	logic [3:0]  s [8] = '{4'h1, 4'h3, 4'h2, 4'h6, 4'h4, 4'hc, 4'h8, 4'h9};
	stepper_feed_mode_sequencer #(
		.FAST_CYCLES(FAST),
		.SLOW_CYCLES(SLOW)
	) i_dut (
		.clk               (clk),
		.rstn              (rstn),
		.func_sel          (func_sel),
		.res_sel           (res_sel),
		.run               (run),
		.cam_home_switch_n (cam_home_switch_n),
		.coil              (coil),
		.hv_enable         (hv_enable),
		.step_pulse        (step_pulse),
		.half_step         (half_step),
		.slow_rate         (slow_rate),
		.step_count        (step_count),
		.cam_home          (cam_home),
		.cam_home_arrive   (cam_home_arrive),
		.func_invalid      (func_invalid)
	);
	feed_motor_model i_motor (
		.clk               (clk),
		.rstn              (rstn),
		.coil              (coil),
		.cam_home_switch_n (cam_home_switch_n)
	);
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task finish_test;
		if (fails == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	function automatic logic sb(input logic [2:0] f);
		return f == 3'h0 || f > 3'h5;
	endfunction
	function automatic logic slw(input logic [2:0] f, input logic [1:0] r);
		return r == 2'h3 && !sb(f) && f < 3'h4;
	endfunction
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#3_000_000;
		fails++;
		finish_test();
	end
	initial begin
		logic [2:0] f;
		logic [1:0] r;
		logic       two;
		int         idx;
		int         cnt;
		rstn = 1'b0;
		func_sel = 3'h0;
		res_sel = 2'h0;
		run = 1'b0;
		rng = 27;
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		idx = 0;
		// every function and resolution pair once, then random ones
		// the phase index carries over stand-by, so idx is kept across passes
		for (int t = 0; t < 40; t++) begin
			rng = xs(rng);
			f = (t < 32) ? t[2:0] : rng[2:0];
			r = (t < 32) ? t[4:3] : rng[4:3];
			two = f == 3'h2 && r == 2'h0;
			func_sel = f;
			res_sel = r;
			run = 1'b1;
			@(negedge clk);
			check("hv_enable", 16'(hv_enable), 16'(!sb(f)));
			check("half_step", 16'(half_step), 16'(!sb(f) && !two));
			check("slow_rate", 16'(slow_rate), 16'(slw(f, r)));
			check("func_invalid", 16'(func_invalid), 16'(f > 3'h5));
			check("coil", 16'(coil), sb(f) ? 16'h0 : 16'(s[idx]));
			for (int n = 1; n <= 3; n++) begin
				cnt = 0;
				do begin
					@(negedge clk);
					cnt++;
				end while (!step_pulse && cnt < 2 * SLOW);
				if (!sb(f))
					idx = (idx + ((two && idx[0]) ? 2 : 1)) % 8;
				check("coil", 16'(coil), sb(f) ? 16'h0 : 16'(s[idx]));
				check("step_count", step_count, sb(f) ? 16'h0 : 16'(n));
				if (n > 1 && !sb(f))
					check("gap", 16'(cnt), slw(f, r) ? 16'(SLOW) : 16'(FAST));
			end
			run = 1'b0;
			@(negedge clk);
			check("hv_enable", 16'(hv_enable), 16'h0);
			check("coil", 16'(coil), sb(f) ? 16'h0 : 16'(s[idx]));
			repeat (4) @(negedge clk);
			check("cam_home", 16'(cam_home), 16'(!cam_home_switch_n));
			func_sel = 3'h0;
			@(negedge clk);
			check("coil", 16'(coil), 16'h0);
		end
		finish_test();
	end
endmodule
`default_nettype wire
